/* design/can_ctrl_pkg.sv */
// constants, types and helper functions shared by the can control block
// Notes on behaviour
// R1: bit length is both segment fields plus one
// R2: sync segment fixed at one quantum
// R3: quantum is module clock over divider; code divides the fixed source clock instead
// R4: bit rate is clock over quanta times divider
// R5: segments, phase two, jump width set separately
// R6: source clock assumed fixed at 8MHz
// R7: disable stops traffic, state kept
// R8: enable sends pending, accepts received frames
// R9: comes up disabled, object memory undefined
// R10: host clears all objects before first enable
// R11: host initialises and sets timing first
// R12: error counts and passive flag readable together
// R13: clear code clears status or object interrupt
// R14: status read clears status interrupt
// R15: object read clears its pending interrupt
// R16: only enabled sources interrupt, master gates all
// R17: object interrupt needs its own enable
// R18: error interrupt on bus-off or counter limit
// R19: status interrupt on transfer done or error
// R20: phase two accepts one to eight
// R21: jump width accepts one to four
// R22: divider accepts one to 1023
// R23: transmit and receive done flags since read
package can_ctrl_pkg;

  // field widths
  localparam int PP1_W   = 4;  // propagation plus phase one quanta
  localparam int PH2_W   = 4;  // phase two quanta
  localparam int SJW_W   = 3;  // resync jump width
  localparam int DIV_W   = 10; // quantum divider
  localparam int QCNT_W  = 5;  // quantum index inside a bit
  localparam int ACC_W   = 5;  // source clock rate accumulator
  localparam int CNT_W   = 9;  // error counter with overflow bit
  localparam int CODE_W  = 6;  // interrupt cause and clear code
  localparam int OBJ_N   = 32; // message objects
  localparam int ONUM_W  = 5;  // object index
  localparam int ERRC_W  = 16; // packed error counter word
  localparam int STAT_W  = 5;  // status word

  // accepted ranges of the timing fields
  localparam logic [DIV_W-1:0] PP1_MIN = 10'h001;
  localparam logic [DIV_W-1:0] PP1_MAX = 10'h00f;
  localparam logic [DIV_W-1:0] PH2_MIN = 10'h001;
  localparam logic [DIV_W-1:0] PH2_MAX = 10'h008;
  localparam logic [DIV_W-1:0] SJW_MIN = 10'h001;
  localparam logic [DIV_W-1:0] SJW_MAX = 10'h004;
  localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;
  localparam logic [DIV_W-1:0] DIV_MAX = 10'h3ff;

  // reset values of the timing fields
  localparam logic [PP1_W-1:0] PP1_RST = 4'h1;
  localparam logic [PH2_W-1:0] PH2_RST = 4'h1;
  localparam logic [SJW_W-1:0] SJW_RST = 3'h1;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h001;

  // sync segment is one fixed quantum
  localparam logic [QCNT_W-1:0] SYNC_QUANTA = 5'h01;

  // source and module clock rates
  localparam int CAN_SRC_HZ = 8000000;
  localparam int CLK_HZ     = 20000000;
  localparam int HZ_UNIT    = 1000000;
  localparam logic [ACC_W-1:0] SRC_STEP = ACC_W'(CAN_SRC_HZ / HZ_UNIT);
  localparam logic [ACC_W-1:0] CLK_STEP = ACC_W'(CLK_HZ / HZ_UNIT);

  // error counter limits and steps
  localparam logic [CNT_W-1:0] ERR_WARN    = 9'h060;
  localparam logic [CNT_W-1:0] ERR_PASSIVE = 9'h080;
  localparam logic [CNT_W-1:0] ERR_BUSOFF  = 9'h100;
  localparam logic [CNT_W-1:0] ERR_MAX     = 9'h1ff;
  localparam logic [CNT_W-1:0] TX_ERR_STEP = 9'h008;
  localparam logic [CNT_W-1:0] RX_ERR_STEP = 9'h001;
  localparam logic [CNT_W-1:0] OK_STEP     = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 9'h000;

  // packed error counter word layout
  localparam int TEC_LSB = 0;
  localparam int REC_LSB = 8;
  localparam int REC_FW  = 7;
  localparam int RP_BIT  = 15;

  // status word bit positions
  localparam int ST_TXOK   = 0;
  localparam int ST_RXOK   = 1;
  localparam int ST_EWARN  = 2;
  localparam int ST_EPASS  = 3;
  localparam int ST_BUSOFF = 4;

  // interrupt cause codes
  localparam logic [CODE_W-1:0] status_interrupt_code = 6'h3f;
  localparam logic [CODE_W-1:0] CAUSE_NONE            = 6'h00;
  localparam logic [CODE_W-1:0] OBJ_CODE_MIN          = 6'h01;
  localparam logic [CODE_W-1:0] OBJ_CODE_MAX          = 6'h20;

  // controller states, one-hot
  typedef enum logic [2:0] {
    CTRL_OFF    = 3'b001,
    CTRL_ON     = 3'b010,
    CTRL_BUSOFF = 3'b100
  } ctrl_e;

  // limit a field to its accepted range
  function automatic logic [DIV_W-1:0] clamp(input logic [DIV_W-1:0] v,
                                             input logic [DIV_W-1:0] lo,
                                             input logic [DIV_W-1:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // saturating add and subtract on error counters
  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    sat_add = (ERR_MAX - a < b) ? ERR_MAX : a + b;
  endfunction

  function automatic logic [CNT_W-1:0] sat_sub(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    sat_sub = (a < b) ? CNT_ZERO : a - b;
  endfunction

  // one-hot of object code 1..32, else zero
  function automatic logic [OBJ_N-1:0] code_to_obj(input logic [CODE_W-1:0] c);
    code_to_obj = '0;
    if (c >= OBJ_CODE_MIN && c <= OBJ_CODE_MAX) begin
      code_to_obj[ONUM_W'(c - OBJ_CODE_MIN)] = 1'b1;
    end
  endfunction

endpackage

/* design/can_bit_timer.sv */
// quantum prescaler and nominal bit segment sequencer
`timescale 1ns/1ns
module can_bit_timer
  import can_ctrl_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic                        run,
  input  wire logic [can_ctrl_pkg::DIV_W-1:0] divider,
  input  wire logic [can_ctrl_pkg::PP1_W-1:0] tseg1,
  input  wire logic [can_ctrl_pkg::PH2_W-1:0] tseg2,
  output logic                             tq_tick_q,
  output logic                             bit_start_q,
  output logic                             sample_pt_q
);

  logic [ACC_W-1:0]  acc_q, acc_d;     // source clock rate accumulator
  logic [DIV_W-1:0]  presc_q, presc_d; // source clock periods into the quantum
  logic [QCNT_W-1:0] qidx_q, qidx_d;   // quantum index in the bit
  logic              tq_d, bs_d, sp_d; // pulse next values
  logic              src_tick;         // one can source clock period
  logic [QCNT_W-1:0] last_q;           // index of the bit's last quantum

  // next state of prescaler and segment counter
  always_comb begin
    acc_d    = acc_q;
    presc_d  = presc_q;
    qidx_d   = qidx_q;
    tq_d     = 1'b0;
    bs_d     = 1'b0;
    sp_d     = 1'b0;
    src_tick = 1'b0;
    // bit holds sync, prop plus phase one, and phase two
    last_q   = QCNT_W'(tseg1) + QCNT_W'(tseg2) + SYNC_QUANTA - SYNC_QUANTA; // [R1] [R2]
    if (run) begin
      // average the fixed source rate out of the module clock
      if (acc_q + SRC_STEP >= CLK_STEP) begin // [R6]
        acc_d    = acc_q + SRC_STEP - CLK_STEP;
        src_tick = 1'b1;
      end else begin
        acc_d = acc_q + SRC_STEP;
      end
      if (src_tick) begin
        // quantum ends after divider source periods
        if (presc_q >= divider - DIV_MIN) begin // [R3]
          presc_d = '0;
          tq_d    = 1'b1;
        end else begin
          presc_d = presc_q + DIV_MIN;
        end
      end
      if (tq_d) begin
        // sample where phase one ends, restart at bit end
        sp_d = (qidx_q == QCNT_W'(tseg1));
        if (qidx_q >= last_q) begin // [R4]
          qidx_d = '0;
          bs_d   = 1'b1;
        end else begin
          qidx_d = qidx_q + SYNC_QUANTA;
        end
      end
    end
  end

  // registers; a stopped timer keeps its position
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_q       <= '0;
      presc_q     <= '0;
      qidx_q      <= '0;
      tq_tick_q   <= 1'b0;
      bit_start_q <= 1'b0;
      sample_pt_q <= 1'b0;
    end else if (clk_en) begin
      acc_q       <= acc_d;
      presc_q     <= presc_d;
      qidx_q      <= qidx_d;
      tq_tick_q   <= tq_d;
      bit_start_q <= bs_d;
      sample_pt_q <= sp_d;
    end
  end

endmodule

/* design/can_timing_enable_interrupt_ctrl.sv */
// can controller timing configuration, enable, error counters and interrupts
`timescale 1ns/1ns
module can_timing_enable_interrupt_ctrl
  import can_ctrl_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            clk_en,
  // timing configuration
  input  wire logic                            timing_wr,
  input  wire logic [can_ctrl_pkg::PP1_W-1:0]  prop_phase1_quanta,
  input  wire logic [can_ctrl_pkg::PH2_W-1:0]  phase2_quanta,
  input  wire logic [can_ctrl_pkg::SJW_W-1:0]  resync_jump_width,
  input  wire logic [can_ctrl_pkg::DIV_W-1:0]  quantum_divider,
  // enable control
  input  wire logic                            enable_wr,
  input  wire logic                            enable_val,
  // protocol engine side
  input  wire logic                            tx_pending,
  input  wire logic                            rx_frame_in,
  input  wire logic                            tx_ok,
  input  wire logic                            rx_ok,
  input  wire logic                            bus_err,
  input  wire logic                            tx_err,
  input  wire logic                            rx_err,
  input  wire logic                            obj_event,
  input  wire logic [can_ctrl_pkg::ONUM_W-1:0] obj_event_num,
  // interrupt configuration and clearing
  input  wire logic [can_ctrl_pkg::OBJ_N-1:0]  obj_int_en,
  input  wire logic                            int_en_master,
  input  wire logic                            int_en_error,
  input  wire logic                            int_en_status,
  input  wire logic                            int_clr,
  input  wire logic [can_ctrl_pkg::CODE_W-1:0] int_clr_code,
  input  wire logic                            status_rd,
  input  wire logic                            obj_rd,
  input  wire logic [can_ctrl_pkg::CODE_W-1:0] obj_rd_code,
  // outputs
  output logic                                 enabled_q,
  output logic                                 tx_start_q,
  output logic                                 rx_accept_q,
  output logic                                 tq_tick_q,
  output logic                                 bit_start_q,
  output logic                                 sample_pt_q,
  output logic [can_ctrl_pkg::PP1_W-1:0]       prop_phase1_q,
  output logic [can_ctrl_pkg::PH2_W-1:0]       phase2_q,
  output logic [can_ctrl_pkg::SJW_W-1:0]       sjw_q,
  output logic [can_ctrl_pkg::DIV_W-1:0]       divider_q,
  output logic [can_ctrl_pkg::ERRC_W-1:0]      err_counter_q,
  output logic                                 err_passive_q,
  output logic [can_ctrl_pkg::STAT_W-1:0]      status_q,
  output logic [can_ctrl_pkg::OBJ_N-1:0]       obj_pending_q,
  output logic [can_ctrl_pkg::CODE_W-1:0]      int_cause_q,
  output logic                                 irq_q
);

  import can_ctrl_pkg::*;

  // timing configuration
  logic [PP1_W-1:0] pp1_d;   // propagation plus phase one next
  logic [PH2_W-1:0] ph2_d;   // phase two next
  logic [SJW_W-1:0] sjw_d;   // jump width next
  logic [DIV_W-1:0] div_d;   // quantum divider next

  // latch fields limited to their accepted ranges
  always_comb begin
    pp1_d = prop_phase1_q;
    ph2_d = phase2_q;
    sjw_d = sjw_q;
    div_d = divider_q;
    if (timing_wr) begin
      pp1_d = PP1_W'(clamp(DIV_W'(prop_phase1_quanta), PP1_MIN, PP1_MAX)); // [R5]
      ph2_d = PH2_W'(clamp(DIV_W'(phase2_quanta), PH2_MIN, PH2_MAX));      // [R20]
      sjw_d = SJW_W'(clamp(DIV_W'(resync_jump_width), SJW_MIN, SJW_MAX));  // [R21]
      div_d = clamp(quantum_divider, DIV_MIN, DIV_MAX);                    // [R22]
    end
  end

  // timing registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prop_phase1_q <= PP1_RST;
      phase2_q      <= PH2_RST;
      sjw_q         <= SJW_RST;
      divider_q     <= DIV_RST;
    end else if (clk_en) begin
      prop_phase1_q <= pp1_d;
      phase2_q      <= ph2_d;
      sjw_q         <= sjw_d;
      divider_q     <= div_d;
    end
  end

  // enable state and error counters
  ctrl_e            state_q, state_d;  // controller state
  logic [CNT_W-1:0] tec_q, tec_d;      // transmit error count
  logic [CNT_W-1:0] rec_q, rec_d;      // receive error count
  logic             running;           // traffic processing allowed
  logic             err_evt;           // error limit reached this cycle
  logic             stat_evt;          // status event this cycle

  assign running  = (state_q == CTRL_ON);
  assign stat_evt = running & (tx_ok | rx_ok | bus_err);

  // next state and counter values
  always_comb begin
    state_d = state_q;
    tec_d   = tec_q;
    rec_d   = rec_q;
    case (state_q)
      CTRL_OFF: begin
        // held off, counters and objects untouched
        if (enable_wr && enable_val) begin
          state_d = CTRL_ON; // [R8]
        end
      end
      CTRL_ON: begin
        if (tx_err) begin
          tec_d = sat_add(tec_q, TX_ERR_STEP);
        end else if (tx_ok) begin
          tec_d = sat_sub(tec_q, OK_STEP);
        end
        if (rx_err) begin
          rec_d = sat_add(rec_q, RX_ERR_STEP);
        end else if (rx_ok) begin
          rec_d = sat_sub(rec_q, OK_STEP);
        end
        if (enable_wr && !enable_val) begin
          state_d = CTRL_OFF; // [R7]
        end else if (tec_d >= ERR_BUSOFF) begin
          state_d = CTRL_BUSOFF;
        end
      end
      CTRL_BUSOFF: begin
        // enable write leaves bus-off with clean counters
        if (enable_wr) begin
          state_d = enable_val ? CTRL_ON : CTRL_OFF;
          tec_d   = CNT_ZERO;
          rec_d   = CNT_ZERO;
        end
      end
      default: begin
        state_d = CTRL_OFF;
      end
    endcase
  end

  // error event on first reaching a limit or bus-off
  always_comb begin
    err_evt = 1'b0;
    if ((tec_d >= ERR_WARN && tec_q < ERR_WARN) || (rec_d >= ERR_WARN && rec_q < ERR_WARN)) begin
      err_evt = 1'b1; // [R18]
    end
    if ((tec_d >= ERR_PASSIVE && tec_q < ERR_PASSIVE) || (rec_d >= ERR_PASSIVE && rec_q < ERR_PASSIVE)) begin
      err_evt = 1'b1; // [R18]
    end
    if (state_d == CTRL_BUSOFF && state_q != CTRL_BUSOFF) begin
      err_evt = 1'b1; // [R18]
    end
  end

  // state registers, reset leaves the controller disabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= CTRL_OFF; // [R9]
      tec_q   <= CNT_ZERO;
      rec_q   <= CNT_ZERO;
    end else if (clk_en) begin
      state_q <= state_d;
      tec_q   <= tec_d;
      rec_q   <= rec_d;
    end
  end

  // bit timing
  can_bit_timer u_timer (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .run         (running),
    .divider     (divider_q),
    .tseg1       (prop_phase1_q),
    .tseg2       (phase2_q),
    .tq_tick_q   (tq_tick_q),
    .bit_start_q (bit_start_q),
    .sample_pt_q (sample_pt_q)
  );

  // flags, pending bits and interrupt
  logic             txf_q, txf_d;       // transmit done since status read
  logic             rxf_q, rxf_d;       // receive done since status read
  logic             spend_q, spend_d;   // status interrupt pending
  logic             epend_q, epend_d;   // error interrupt pending
  logic [OBJ_N-1:0] pend_d;             // object pending next
  logic [OBJ_N-1:0] obj_set;            // objects raising now
  logic [OBJ_N-1:0] obj_clr;            // objects cleared now
  logic             stat_clr;           // status interrupt clear
  logic             cause_hit;          // status or error source active
  logic [CODE_W-1:0] cause_d;           // cause code next
  logic             irq_d;              // interrupt line next
  logic [ERRC_W-1:0] errc_d;            // packed counter word next
  logic [STAT_W-1:0] stat_d;            // status word next

  // lowest numbered pending object as a code 1..32
  function automatic logic [CODE_W-1:0] first_obj(input logic [OBJ_N-1:0] p);
    first_obj = CAUSE_NONE;
    for (int i = OBJ_N - 1; i >= 0; i--) begin
      if (p[i]) begin
        first_obj = CODE_W'(i) + OBJ_CODE_MIN;
      end
    end
  endfunction

  // sticky flags; an event in the clearing cycle wins
  always_comb begin
    stat_clr = status_rd || (int_clr && int_clr_code == status_interrupt_code); // [R13] [R14]
    obj_clr  = (int_clr ? code_to_obj(int_clr_code) : '0)                       // [R13]
             | (obj_rd ? code_to_obj(obj_rd_code) : '0);                        // [R15]
    obj_set  = '0;
    if (running && obj_event && obj_int_en[obj_event_num]) begin
      obj_set[obj_event_num] = 1'b1; // [R17]
    end
    txf_d   = (running & tx_ok) | (txf_q & ~status_rd);  // [R23]
    rxf_d   = (running & rx_ok) | (rxf_q & ~status_rd);  // [R23]
    spend_d = stat_evt | (spend_q & ~stat_clr);          // [R19]
    epend_d = err_evt | (epend_q & ~stat_clr);           // [R18]
    pend_d  = obj_set | (obj_pending_q & ~obj_clr);
  end

  // cause code, interrupt line and readable words
  always_comb begin
    cause_hit = (spend_d & int_en_status) | (epend_d & int_en_error);                 // [R16]
    cause_d   = cause_hit ? status_interrupt_code : first_obj(pend_d);
    irq_d     = int_en_master & (cause_hit | (|pend_d));                             // [R16]
    errc_d    = '0;
    errc_d[TEC_LSB +: 8]      = tec_d[7:0];                                          // [R12]
    errc_d[REC_LSB +: REC_FW] = rec_d[REC_FW-1:0];                                   // [R12]
    errc_d[RP_BIT]            = (rec_d >= ERR_PASSIVE);                              // [R12]
    stat_d            = '0;
    stat_d[ST_TXOK]   = txf_d;
    stat_d[ST_RXOK]   = rxf_d;
    stat_d[ST_EWARN]  = (tec_d >= ERR_WARN) | (rec_d >= ERR_WARN);
    stat_d[ST_EPASS]  = (tec_d >= ERR_PASSIVE) | (rec_d >= ERR_PASSIVE);
    stat_d[ST_BUSOFF] = (state_d == CTRL_BUSOFF);
  end

  // interrupt and status registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txf_q         <= 1'b0;
      rxf_q         <= 1'b0;
      spend_q       <= 1'b0;
      epend_q       <= 1'b0;
      obj_pending_q <= '0;
      int_cause_q   <= CAUSE_NONE;
      irq_q         <= 1'b0;
      err_counter_q <= '0;
      err_passive_q <= 1'b0;
      status_q      <= '0;
    end else if (clk_en) begin
      txf_q         <= txf_d;
      rxf_q         <= rxf_d;
      spend_q       <= spend_d;
      epend_q       <= epend_d;
      obj_pending_q <= pend_d;
      int_cause_q   <= cause_d;
      irq_q         <= irq_d;
      err_counter_q <= errc_d;
      err_passive_q <= errc_d[RP_BIT]; // [R12]
      status_q      <= stat_d;
    end
  end

  // traffic gating
  logic tx_start_d;  // pending frame may go out
  logic rx_acc_d;    // received frame may be processed

  // only an enabled controller touches the bus
  always_comb begin
    tx_start_d = (state_d == CTRL_ON) & tx_pending;  // [R8] [R7]
    rx_acc_d   = (state_d == CTRL_ON) & rx_frame_in; // [R8] [R7]
  end

  // gating registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enabled_q   <= 1'b0; // [R9]
      tx_start_q  <= 1'b0;
      rx_accept_q <= 1'b0;
    end else if (clk_en) begin
      enabled_q   <= (state_d == CTRL_ON);
      tx_start_q  <= tx_start_d;
      rx_accept_q <= rx_acc_d;
    end
  end

endmodule

/* tb/can_engine_model.sv */
// engine stand-in: answers each transmit start
`timescale 1ns/1ns
module can_engine_model (
  input  wire logic clk,
  input  wire logic tx_start_q,
  input  wire logic slow,
  output logic      tx_ok
);
  logic was_q = 1'b0; // last start level
  initial tx_ok = 1'b0;
  // prompt or slow answer per start
  always @(negedge clk) begin
    was_q <= tx_start_q;
    if (tx_start_q && !was_q) begin
      repeat (slow ? 12 : 2) @(negedge clk);
      tx_ok <= 1'b1;
      @(negedge clk);
      tx_ok <= 1'b0;
    end
  end
endmodule

/* tb/can_ctrl_sva.sv */
// port checks of the can control block
`timescale 1ns/1ns
module can_ctrl_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        timing_wr,
  input wire logic        tx_pending,
  input wire logic        tx_ok,
  input wire logic        obj_event,
  input wire logic [4:0]  obj_event_num,
  input wire logic [31:0] obj_int_en,
  input wire logic        int_en_master,
  input wire logic        enabled_q,
  input wire logic        tx_start_q,
  input wire logic        tq_tick_q,
  input wire logic        bit_start_q,
  input wire logic        sample_pt_q,
  input wire logic [3:0]  prop_phase1_q,
  input wire logic [3:0]  phase2_q,
  input wire logic [9:0]  divider_q,
  input wire logic [15:0] err_counter_q,
  input wire logic        err_passive_q,
  input wire logic [4:0]  status_q,
  input wire logic [31:0] obj_pending_q,
  input wire logic        irq_q
);
  logic [4:0] qcnt_q, qcnt_d;   // quanta since the last bit boundary
  logic       valid_q, valid_d; // a bit boundary passed since the last timing write
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // quanta per bit, void after a timing write
  always_comb begin
    qcnt_d = !clk_en ? qcnt_q : (bit_start_q ? 5'h00 : qcnt_q + 5'(tq_tick_q));
    valid_d = (clk_en && timing_wr) ? 1'b0 : (valid_q | (clk_en & bit_start_q));
  end
  // register the helper state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      qcnt_q <= 5'h00;
      valid_q <= 1'b0;
    end else begin
      qcnt_q <= qcnt_d;
      valid_q <= valid_d;
    end
  end
  AST_BIT_LEN: assert property (valid_q && bit_start_q |-> qcnt_q == prop_phase1_q + phase2_q)
    else $error("bad bit length");
  AST_SAMPLE: assert property (valid_q && sample_pt_q |-> tq_tick_q && qcnt_q == 5'(prop_phase1_q))
    else $error("sample point misplaced");
  AST_PH2: assert property (clk_en && timing_wr |=> phase2_q inside {[1:8]} && divider_q != 10'h000)
    else $error("timing out of range");
  AST_TX_QUIET: assert property (tx_start_q |-> enabled_q)
    else $error("start while off");
  AST_TX_FOLLOW: assert property (clk_en && tx_pending ##1 enabled_q |-> tx_start_q)
    else $error("frame not started");
  AST_IRQ_MASTER: assert property (clk_en && !int_en_master |=> !irq_q)
    else $error("irq without master");
  AST_PASSIVE: assert property (err_passive_q == err_counter_q[15] && (!err_passive_q || status_q[3]))
    else $error("bad passive flag");
  AST_TXOK: assert property (clk_en && enabled_q && tx_ok |=> status_q[0])
    else $error("tx done not set");
  AST_OBJ_SET: assert property (clk_en && enabled_q && obj_event && obj_int_en[obj_event_num]
    |=> obj_pending_q[$past(obj_event_num)])
    else $error("object not pending");
endmodule
bind can_timing_enable_interrupt_ctrl can_ctrl_sva can_ctrl_sva_inst (.*);

/* tb/tb_top.sv */
// bench for the can timing, enable and interrupt control
`timescale 1ns/1ns
module tb_top;
  import can_ctrl_pkg::*;
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, slow = 1'b0, tx_ok;
  logic timing_wr = 1'b0, enable_wr = 1'b0, enable_val = 1'b0, tx_pending = 1'b0;
  logic rx_frame_in = 1'b0, rx_ok = 1'b0, bus_err = 1'b0, tx_err = 1'b0, rx_err = 1'b0;
  logic obj_event = 1'b0, int_clr = 1'b0, status_rd = 1'b0, obj_rd = 1'b0;
  logic int_en_master = 1'b0, int_en_error = 1'b0, int_en_status = 1'b0;
  logic [3:0]  prop_phase1_quanta = 4'h0, phase2_quanta = 4'h0, prop_phase1_q, phase2_q;
  logic [2:0]  resync_jump_width = 3'h0, sjw_q;
  logic [9:0]  quantum_divider = 10'h000, divider_q;
  logic [4:0]  obj_event_num = 5'h00, status_q;
  logic [31:0] obj_int_en = 32'h0, obj_pending_q;
  logic [5:0]  int_clr_code = 6'h00, obj_rd_code = 6'h00, int_cause_q;
  logic [15:0] err_counter_q;
  logic        enabled_q, tx_start_q, rx_accept_q, tq_tick_q, bit_start_q, sample_pt_q, err_passive_q, irq_q;
  int          failures = 0, checks_done = 0;
  can_timing_enable_interrupt_ctrl can_timing_enable_interrupt_ctrl_inst (.*);
  can_engine_model can_engine_model_inst (.*);
  always #25 clk = ~clk;
  // closing report
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // compare one observed value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle strobe, then one idle cycle
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask
  // write all timing fields together
  task automatic cfg(input logic [3:0] a, input logic [3:0] b, input logic [2:0] c, input logic [9:0] d);
    prop_phase1_quanta = a;
    phase2_quanta = b;
    resync_jump_width = c;
    quantum_divider = d;
    pulse(timing_wr);
  endtask
  task automatic en(input logic v);
    enable_val = v;
    pulse(enable_wr);
  endtask
  // count timer pulses over a window
  task automatic count(input int n, output int nt, output int nb, output int ns);
    nt = 0;
    nb = 0;
    ns = 0;
    repeat (n) begin
      @(negedge clk);
      nt += tq_tick_q;
      nb += bit_start_q;
      ns += sample_pt_q;
    end
  endtask
  task automatic t_reset();
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk("enabled", enabled_q, 1'b0);
    chk("errcnt", err_counter_q, 16'h0000);
    chk("div", divider_q, 10'h001);
  endtask
  // clamping, then 10 bits of 8 quanta in 400 cycles
  task automatic t_timing();
    int nt, nb, ns;
    cfg(4'h0, 4'h9, 3'h7, 10'h000);
    chk("ph2", phase2_q, 4'h8);
    chk("sjw", sjw_q, 3'h4);
    chk("div", divider_q, 10'h001);
    chk("pp1", prop_phase1_q, 4'h1);
    cfg(4'h5, 4'h2, 3'h1, 10'h3ff);
    chk("divmax", divider_q, 10'h3ff);
    cfg(4'h5, 4'h2, 3'h1, 10'h002);
    en(1'b1);
    repeat (80) @(negedge clk);
    count(400, nt, nb, ns);
    chk("quanta", nt, 32'd80);
    chk("bits", nb, 32'd10);
    chk("samples", ns, 32'd10);
  endtask
  // enable gating, prompt and slow partner
  task automatic t_enable();
    int nt, nb, ns, k;
    en(1'b0);
    tx_pending = 1'b1;
    rx_frame_in = 1'b1;
    count(40, nt, nb, ns);
    chk("idle", nt, 32'd0);
    chk("held", {tx_start_q, rx_accept_q}, 2'b00);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      tx_pending = 1'b1;
      en(1'b1);
      chk("start", {tx_start_q, rx_accept_q}, 2'b11);
      for (k = 0; k < 40 && status_q[ST_TXOK] !== 1'b1; k++) @(negedge clk);
      chk("txdone", status_q[ST_TXOK], 1'b1);
      tx_pending = 1'b0;
      en(1'b0);
      chk("kept", status_q[ST_TXOK], 1'b1);
      pulse(status_rd);
      chk("rdclr", status_q[1:0], 2'b00);
    end
  endtask
  task automatic t_irq();
    en(1'b1);
    obj_int_en = 32'h0000_0004;
    obj_event_num = 5'h02;
    pulse(obj_event);
    chk("cause3", int_cause_q, 6'h03);
    chk("nomaster", irq_q, 1'b0);
    int_en_master = 1'b1;
    @(negedge clk);
    chk("master", irq_q, 1'b1);
    obj_rd_code = 6'h03;
    pulse(obj_rd);
    chk("objrd", irq_q, 1'b0);
    obj_event_num = 5'h05;
    pulse(obj_event);
    chk("objoff", obj_pending_q, 32'h0);
    obj_int_en = 32'hffff_ffff;
    obj_event_num = 5'h1f;
    pulse(obj_event);
    chk("cause32", int_cause_q, 6'h20);
    int_clr_code = 6'h20;
    pulse(int_clr);
    chk("clr32", obj_pending_q, 32'h0);
    int_en_status = 1'b1;
    pulse(bus_err);
    chk("stcause", int_cause_q, status_interrupt_code);
    chk("stirq", irq_q, 1'b1);
    int_clr_code = status_interrupt_code;
    pulse(int_clr);
    chk("stclr", irq_q, 1'b0);
    int_en_status = 1'b0;
    pulse(bus_err);
    chk("stoff", irq_q, 1'b0);
    pulse(status_rd);
  endtask
  // error limits, passive and bus-off
  task automatic t_err();
    int_en_error = 1'b1;
    repeat (95) pulse(rx_err);
    chk("below", irq_q, 1'b0);
    pulse(rx_err);
    chk("warn", irq_q, 1'b1);
    pulse(status_rd);
    repeat (32) pulse(rx_err);
    chk("passive", err_passive_q, 1'b1);
    chk("counter", err_counter_q, 16'h8000);
    chk("pirq", irq_q, 1'b1);
    repeat (32) pulse(tx_err);
    chk("busoff", {enabled_q, status_q[4:2]}, 4'h7);
  endtask
  initial begin
    t_reset();
    t_timing();
    t_enable();
    t_irq();
    t_err();
    t_reset();
    end_of_test();
  end
  // hang guard
  initial begin
    #(50 * 60000);
    failures++;
    end_of_test();
  end
endmodule
